// *** design/bst_pkg.sv ***
package bst_pkg;

  // Controller states
  typedef enum logic [3:0] {
    BST_RESET, BST_IDLE, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR, BST_PAU_DR,
    BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR, BST_PAU_IR,
    BST_EX2_IR, BST_UPD_IR
  } bst_state_t;

  localparam int BST_IR_W = 4;
  localparam int BST_ID_W = 32;
  // Instruction codes
  localparam logic [3:0] BST_OP_EXTEST = 4'h0;
  localparam logic [3:0] BST_OP_IDCODE = 4'h2;
  localparam logic [3:0] BST_OP_BYPASS = 4'hf;
  // Reset value of the instruction register selects bypass
  localparam logic [3:0] BST_IR_RST = 4'hf;
  // Fixed capture pattern of the instruction register
  localparam logic [3:0] BST_IR_CAPTURE = 4'h1;
  // Synchroniser reset: test clock low, pulled-up pins high
  localparam logic [3:0] BST_PIN_RST = 4'h7;
  // Mode-select high rises in a row that force the controller to reset
  localparam logic [2:0] BST_TMS_RST_N = 3'h5;
  // Identification value, arbitrary
  localparam logic [31:0] BST_ID_RST = 32'h0000_1001;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_pins_t;

endpackage

// *** design/bst_tap.sv ***
`timescale 1ns/1ps
//Operation
// RULE_01: Four test terminals; all test operations follow the test clock.
// RULE_02: Inputs sampled on rising test clock edge; outputs change on falling edge.
// RULE_03: Data input shifts into instruction, identification or bypass register.
// RULE_04: Data output presents selected register bit, updated on falling edge.
// RULE_05: Data output driven only in shift-DR and shift-IR states.
// RULE_06: Mode select steers the controller between states.
// RULE_07: Active-low test reset resets controller at once, no test clock needed.
// RULE_08: No power-up self reset; test reset or five high mode-select clocks. Code loads BST_RESET on rst; only seen_rst and tdo_oe wait.
// RULE_09: Outputs stay high impedance until the controller has been reset.
// RULE_10: Unused port: far side holds test clock and test reset low.
// RULE_11: Without a test reset driver, far side may tie it to master reset.
// RULE_12: Undriven mode select, data input or test reset read as high.
// RULE_13: Standard sixteen-state controller; one-bit bypass selected after reset.
module bst_tap (
  // System
  input wire logic core_clk,
  input wire logic rst,
  // Test pins, raw; *_z high means the pin is floating
  input wire bst_pkg::bst_pins_t pins,
  input wire logic tms_z,
  input wire logic tdi_z,
  input wire logic trst_z,
  // Test data out
  output logic tdo_o,
  output logic tdo_oe,
  // Status
  output logic tap_in_reset
);
  import bst_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pull-ups and three-stage sampling
  bst_pins_t pin_eff;
  logic [3:0] s1_reg, s2_reg, s3_reg;
  logic [3:0] s1_next, s2_next, s3_next;
  logic [3:0] f_reg, f_next;

  always_comb begin
    pin_eff = pins;
    pin_eff.tms = pins.tms | tms_z;       // [RULE_12]
    pin_eff.tdi = pins.tdi | tdi_z;       // [RULE_12]
    pin_eff.trst_n = pins.trst_n | trst_z; // [RULE_12]
    s1_next = pin_eff;
    s2_next = s1_reg;
    s3_next = s2_reg;
    f_next = f_reg;
    // A change counts once the last two stages agree
    for (int i = 0; i < 4; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        f_next[i] = s3_reg[i];
      end
    end
  end

  // Idle levels on reset, so no false clock edge or test reset follows it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= BST_PIN_RST;
      s2_reg <= BST_PIN_RST;
      s3_reg <= BST_PIN_RST;
      f_reg <= BST_PIN_RST;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      f_reg <= f_next;
    end
  end

  bst_pins_t fp;
  logic tck_d_reg, tck_d_next;
  logic tck_rise, tck_fall, trst_act;
  always_comb begin
    fp = f_reg;
    // Edge detector starts at the clock's idle low level
    tck_d_next = fp.tck;
    tck_rise = fp.tck & ~tck_d_reg;       // [RULE_01] [RULE_02]
    tck_fall = ~fp.tck & tck_d_reg;       // [RULE_02]
    trst_act = ~fp.trst_n;                // No clock edge needed [RULE_07]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controller and registers
  bst_state_t st_reg, st_next;
  logic [3:0] ir_reg, ir_next, irsh_reg, irsh_next;
  logic [31:0] id_reg, id_next;
  logic byp_reg, byp_next;
  logic seen_rst_reg, seen_rst_next;
  // Consecutive high mode-select rises
  logic [2:0] hi_cnt_reg, hi_cnt_next;
  logic tdo_reg, tdo_next, oe_reg, oe_next, inr_reg, inr_next;

  // Data register chosen by the active instruction
  function automatic logic sel_id(input logic [3:0] ir);
    return ir == BST_OP_IDCODE;
  endfunction

  always_comb begin
    st_next = st_reg;
    ir_next = ir_reg;
    irsh_next = irsh_reg;
    id_next = id_reg;
    byp_next = byp_reg;
    seen_rst_next = seen_rst_reg;
    tdo_next = tdo_reg;
    oe_next = oe_reg;
    hi_cnt_next = hi_cnt_reg;
    if (tck_rise) begin
      case (st_reg) // [RULE_06] [RULE_13]
        BST_RESET:  st_next = fp.tms ? BST_RESET  : BST_IDLE;
        BST_IDLE:   st_next = fp.tms ? BST_SEL_DR : BST_IDLE;
        BST_SEL_DR: st_next = fp.tms ? BST_SEL_IR : BST_CAP_DR;
        BST_CAP_DR: st_next = fp.tms ? BST_EX1_DR : BST_SH_DR;
        BST_SH_DR:  st_next = fp.tms ? BST_EX1_DR : BST_SH_DR;
        BST_EX1_DR: st_next = fp.tms ? BST_UPD_DR : BST_PAU_DR;
        BST_PAU_DR: st_next = fp.tms ? BST_EX2_DR : BST_PAU_DR;
        BST_EX2_DR: st_next = fp.tms ? BST_UPD_DR : BST_SH_DR;
        BST_UPD_DR: st_next = fp.tms ? BST_SEL_DR : BST_IDLE;
        BST_SEL_IR: st_next = fp.tms ? BST_RESET  : BST_CAP_IR;
        BST_CAP_IR: st_next = fp.tms ? BST_EX1_IR : BST_SH_IR;
        BST_SH_IR:  st_next = fp.tms ? BST_EX1_IR : BST_SH_IR;
        BST_EX1_IR: st_next = fp.tms ? BST_UPD_IR : BST_PAU_IR;
        BST_PAU_IR: st_next = fp.tms ? BST_EX2_IR : BST_PAU_IR;
        BST_EX2_IR: st_next = fp.tms ? BST_UPD_IR : BST_SH_IR;
        BST_UPD_IR: st_next = fp.tms ? BST_SEL_DR : BST_IDLE;
        default:    st_next = BST_RESET;
      endcase
      // Register actions of the state being left
      case (st_reg)
        BST_RESET: begin
          ir_next = BST_IR_RST;               // Bypass by default [RULE_13]
        end
        // Capture loads fixed values before shifting
        BST_CAP_DR: begin
          id_next = BST_ID_RST;
          byp_next = 1'b0;
        end
        BST_SH_DR: begin
          if (sel_id(ir_reg)) begin
            id_next = {fp.tdi, id_reg[31:1]};  // [RULE_03]
          end else begin
            byp_next = fp.tdi;                 // [RULE_03]
          end
        end
        BST_CAP_IR: irsh_next = BST_IR_CAPTURE;
        BST_SH_IR: irsh_next = {fp.tdi, irsh_reg[3:1]}; // [RULE_03]
        BST_UPD_IR: ir_next = irsh_reg;
        default: ;
      endcase

      // Power-up state is not trusted; besides the test reset, only five high rises in a row mark reset
      if (!fp.tms) begin
        hi_cnt_next = 3'h0;
      end else if (hi_cnt_reg != BST_TMS_RST_N) begin
        hi_cnt_next = hi_cnt_reg + 3'h1;
      end
      if (hi_cnt_next == BST_TMS_RST_N) begin
        seen_rst_next = 1'b1;                 // [RULE_08]
      end
    end
    if (tck_fall) begin
      // Falling-edge output update [RULE_02] [RULE_04]
      oe_next = seen_rst_reg && (st_reg == BST_SH_DR || st_reg == BST_SH_IR); // [RULE_05] [RULE_09]
      // Instruction shift shows the instruction register, else the data register
      if (st_reg == BST_SH_IR) begin
        tdo_next = irsh_reg[0];
      end else if (sel_id(ir_reg)) begin
        tdo_next = id_reg[0];
      end else begin
        tdo_next = byp_reg;
      end
    end
    // Needs no test clock; only the pin's sampling latency applies
    if (trst_act) begin
      st_next = BST_RESET;                    // [RULE_07]
      ir_next = BST_IR_RST;
      seen_rst_next = 1'b1;
      hi_cnt_next = 3'h0;
      oe_next = 1'b0;
    end
    // Status follows the state being entered, so it changes with the state
    inr_next = (st_next == BST_RESET);
  end

  // Power-up loads the controller into BST_RESET, but seen_rst stays low until reset [RULE_08]
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tck_d_reg <= 1'b0;
      hi_cnt_reg <= 3'h0;
      st_reg <= BST_RESET;
      ir_reg <= BST_IR_RST;
      irsh_reg <= BST_IR_RST;
      id_reg <= BST_ID_RST;
      byp_reg <= 1'b0;
      seen_rst_reg <= 1'b0;
      tdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      inr_reg <= 1'b0;
    end else begin
      tck_d_reg <= tck_d_next;
      hi_cnt_reg <= hi_cnt_next;
      st_reg <= st_next;
      ir_reg <= ir_next;
      irsh_reg <= irsh_next;
      id_reg <= id_next;
      byp_reg <= byp_next;
      seen_rst_reg <= seen_rst_next;
      tdo_reg <= tdo_next;
      oe_reg <= oe_next;
      inr_reg <= inr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign tdo_o = tdo_reg;
  assign tdo_oe = oe_reg;
  assign tap_in_reset = inr_reg;

endmodule

// *** tb/bst_ctl.sv ***
`timescale 1ns/1ps
module bst_ctl (
  output bst_pkg::bst_pins_t pins,
  input wire logic tdo_o,
  input wire logic tdo_oe
);
  import bst_pkg::*;
  initial pins = 4'h0; // Port parked: clock and test reset low
  task automatic hold_reset(input logic on);
    pins.trst_n = !on; // Also stands for a master reset tied to it
  endtask
  task automatic step(input logic ms, input logic di, output logic [1:0] seen);
    pins.tms = ms;
    pins.tdi = di;
    #80 pins.tck = 1'h1;
    // Read late but before an edge: the output lags the fall by several core cycles
    #78 seen = {tdo_oe, tdo_o};
    #2 pins.tck = 1'h0;
  endtask
endmodule

// *** tb/bst_tap_monitor.sv ***
`timescale 1ns/1ps
module bst_tap_monitor (
  // System
  input wire logic core_clk,
  input wire logic rst,
  // Test pins
  input wire bst_pkg::bst_pins_t pins,
  input wire logic tms_z,
  input wire logic tdi_z,
  input wire logic trst_z,
  // Outputs
  input wire logic tdo_o,
  input wire logic tdo_oe,
  input wire logic tap_in_reset
);
  import bst_pkg::*;
  logic t_reg, t_next, s_reg, s_next;
  logic [2:0] h_reg, h_next;
  logic [3:0] f_reg, f_next;
  wire trst_on = !pins.trst_n && !trst_z;
  wire tms_hi = pins.tms || tms_z;
  always_comb begin
    t_next = pins.tck;
    f_next = (t_reg && !pins.tck) ? 4'h0 : f_reg + {3'h0, f_reg != 4'hf};
    h_next = h_reg;
    if (!t_reg && pins.tck) begin
      h_next = !tms_hi ? 3'h0 : h_reg + {2'h0, h_reg != BST_TMS_RST_N};
    end
    // Reset seen once the pin asserts or five high mode-select rises pass
    s_next = s_reg | trst_on | (h_reg == BST_TMS_RST_N);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      t_reg <= 1'h0;
      f_reg <= 4'hf;
      h_reg <= 3'h0;
      s_reg <= 1'h0;
    end else begin
      t_reg <= t_next;
      f_reg <= f_next;
      h_reg <= h_next;
      s_reg <= s_next;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence trst_held; trst_on [*8]; endsequence
  sequence tck_still; ($stable(pins.tck) && !trst_on) [*8]; endsequence
  AST_TRST_RESET: assert property (trst_held |-> tap_in_reset) else $error("reset");
  AST_TRST_HOLD: assert property (tap_in_reset && trst_on |=> tap_in_reset) else $error("hold");
  AST_RESET_HIZ: assert property (tap_in_reset |-> !tdo_oe) else $error("hiz");
  AST_UNRESET_HIZ: assert property (!s_reg |-> !tdo_oe) else $error("unreset");
  AST_OE_FALL: assert property ($changed(tdo_oe) && !trst_on |-> f_reg inside {[2:7]})
    else $error("oe edge");
  AST_TDO_FALL: assert property (tdo_oe && $changed(tdo_o) |-> f_reg inside {[2:7]})
    else $error("tdo edge");
  AST_TCK_OUT: assert property (tck_still |-> $stable(tdo_o) && $stable(tdo_oe))
    else $error("no tck");
  AST_TCK_STATE: assert property (tck_still |-> $stable(tap_in_reset)) else $error("state");
endmodule

bind bst_tap bst_tap_monitor u_mon (.core_clk, .rst, .pins, .tms_z, .tdi_z, .trst_z, .tdo_o,
  .tdo_oe, .tap_in_reset);

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t mismatch got %h", $time, a); end end
module testbench;
  import bst_pkg::*;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic tms_z = 1'h0;
  logic tdi_z = 1'h0;
  logic trst_z = 1'h0;
  bst_pins_t pins;
  logic tdo_o, tdo_oe, tap_in_reset;
  logic [1:0] s;
  logic [31:0] q;
  int bad_count = 0;
  int total_checks = 0;
  always #10 core_clk = ~core_clk;
  bst_ctl i_ctl (.pins, .tdo_o, .tdo_oe);
  bst_tap i_dut (.core_clk, .rst, .pins, .tms_z, .tdi_z, .trst_z, .tdo_o, .tdo_oe, .tap_in_reset);
  task automatic walk(input logic [7:0] ms, input int n);
    for (int i = 0; i < n; i++) i_ctl.step(ms[i], 1'h0, s);
  endtask
  task automatic scan(input logic [31:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      i_ctl.step(i == n - 1, d[i], s);
      `CHK(s[1], 1'h1)
      q[i] = s[0];
    end
    i_ctl.step(1'h1, 1'h0, s);
    `CHK(s[1], 1'h0)
  endtask
  task automatic pin_z(input logic [2:0] v);
    @(posedge core_clk);
    #1 {tms_z, tdi_z, trst_z} = v;
  endtask
  task automatic conclude;
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_unreset;
    walk(8'h02, 6);
    `CHK({s[1], tap_in_reset}, 2'h0)
  endtask
  task automatic t_float_reset;
    pin_z(3'h4);
    walk(8'h00, 5);
    pin_z(3'h0);
    `CHK(tap_in_reset, 1'h1)
  endtask
  task automatic t_bypass;
    walk(8'h02, 4);
    scan(32'hd, 5);
    `CHK(q[4:0], 5'h1a)
    pin_z(3'h2);
    walk(8'h02, 4);
    scan(32'h0, 5);
    pin_z(3'h0);
    `CHK(q[4:0], 5'h1e)
  endtask
  task automatic t_trst;
    walk(8'h02, 4);
    pin_z(3'h1);
    i_ctl.hold_reset(1'h1);
    repeat (10) @(posedge core_clk);
    #1;
    `CHK({tdo_oe, tap_in_reset}, 2'h2)
    pin_z(3'h0);
    repeat (10) @(posedge core_clk);
    #1;
    `CHK({tdo_oe, tap_in_reset}, 2'h1)
    i_ctl.hold_reset(1'h0);
  endtask
  task automatic t_idcode;
    walk(8'h06, 5);
    scan({28'h0, BST_OP_IDCODE}, 4);
    `CHK(q[3:0], BST_IR_CAPTURE)
    walk(8'h01, 3);
    scan(32'h0, 32);
    `CHK(q, BST_ID_RST)
  endtask
  initial begin
    @(posedge core_clk);
    #1 i_ctl.hold_reset(1'h0);
    @(posedge core_clk);
    #1 rst = 1'h0;
    t_unreset();
    t_float_reset();
    t_bypass();
    t_trst();
    t_idcode();
    conclude();
  end
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule
